// ---- inc/adc_i2c_pkg.sv ----
// What this block does
// R1: Result is 24-bit two's complement, sign on top
// R2: Out-of-range input clamps to extreme codes
// R3: Result bytes read-only at 0x04..0x06
// R4: Power-down bit stops the conversion circuitry
// R5: Output low byte shadowed until high written
// R6: Slave only, never drives clock line
// R7: Both lines open drain, pull low or release
// R8: Oscillator strap low gives address 0xa0
// R9: Strap high picks address from two pins
// R10: Reduced-pin variant fixes address at 0xd0
// R11: Software keeps interface mode bit zero
// R12: Debounce field selects 0, 2, 4 clocks
// R13: Start and stop from data edge, clock high
// R14: Data sampled while clock high
// R15: Eight bits MSB first plus acknowledge bit
// R16: Low acknowledge continues, high ends transfer
// R17: Read: index write, repeated start, read byte
// R18: Write: address, index, data byte stored
// R19: Acknowledge only own selected address
package adc_i2c_pkg;
  localparam logic [7:0] RESULT_LOW_OFS   = 8'h04;
  localparam logic [7:0] RESULT_MID_OFS   = 8'h05;
  localparam logic [7:0] RESULT_HIGH_OFS  = 8'h06;
  localparam logic [7:0] CONV_CTRL_OFS    = 8'h01;
  localparam logic [7:0] OUT_LOW_OFS      = 8'h0b;
  localparam logic [7:0] OUT_HIGH_OFS     = 8'h0c;
  localparam logic [7:0] SER_CTRL_OFS     = 8'h0e;
  localparam int         MODE_BIT         = 7;
  localparam int         DEB_LSB          = 2;
  localparam int         PWR_DOWN_BIT     = 7;
  localparam logic [7:0] SER_CTRL_MASK    = 8'h8c;
  localparam logic [7:0] SER_CTRL_RESET   = 8'h00;
  localparam logic [7:0] CONV_CTRL_RESET  = 8'h00;
  localparam logic [7:0] ADDR_BASE        = 8'ha0;
  localparam logic [7:0] ADDR_FIXED       = 8'hd0;
  localparam logic [2:0] DEB_CLKS_TWO     = 3'h2;
  localparam logic [2:0] DEB_CLKS_FOUR    = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam logic [23:0] RESULT_MAX      = 24'h7fffff;
  localparam logic [23:0] RESULT_MIN      = 24'h800000;
  localparam int         RAW_W            = 26;
  localparam int         SCL = 1;
  localparam int         SDA = 0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK
  } phase_t;

  typedef enum logic [1:0] {
    K_ADDR, K_INDEX, K_DATA
  } byte_kind_t;

  typedef struct packed {
    logic       sda_o;
    logic       sda_oe;
    logic       scl_o;
    logic       scl_oe;
  } pins_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] filt;
    logic [1:0] filt_prev;
    logic [2:0] cnt_scl;
    logic [2:0] cnt_sda;
  } line_t;
endpackage

// ---- tb/adc_result_i2c_slave_port_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_result_i2c_slave_port_properties (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        scl_o,
  input  wire logic        scl_oe_o,
  input  wire logic        sda_o,
  input  wire logic        sda_oe_o,
  input  wire logic        converter_power_down_o,
  input  wire logic        conv_enable_o,
  input  wire logic [15:0] output_value_o,
  input  wire logic        interface_mode_bit_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Bit high phase is six clocks, so five already proves the window
  sequence scl_held_high;
    scl_i [*5];
  endsequence
  sequence low_bit_held;
    sda_oe_o [*8];
  endsequence
  sequence start_seen;
    scl_i && $fell(sda_i);
  endsequence
  sequence stop_seen;
    scl_i && $rose(sda_i);
  endsequence
  sequence reg_update;
    $changed({converter_power_down_o, interface_mode_bit_o, output_value_o});
  endsequence
  AST_NO_CLOCK_DRIVE: assert property (!scl_oe_o && !scl_o)
    else $error("slave drove the clock line");
  AST_OPEN_DRAIN: assert property (!sda_o)
    else $error("data line driven high");
  AST_POWER_ENABLE: assert property (conv_enable_o == !converter_power_down_o)
    else $error("converter enable not inverse of power down");
  AST_STABLE_SCL_HIGH: assert property (scl_held_high |-> $stable(sda_oe_o))
    else $error("data changed while clock high");
  AST_BIT_HELD: assert property ($rose(sda_oe_o) |-> low_bit_held)
    else $error("low bit released too early");
  AST_REG_AFTER_BYTE: assert property (reg_update |-> $rose(sda_oe_o))
    else $error("register changed away from a received byte");
  AST_STOP_RELEASE: assert property (stop_seen |=> !sda_oe_o [*6])
    else $error("data driven after stop");
  AST_START_QUIET: assert property (start_seen |=> !sda_oe_o [*6])
    else $error("data driven after start");
endmodule // adc_result_i2c_slave_port_properties

bind adc_result_i2c_slave_port adc_result_i2c_slave_port_properties props_i (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .converter_power_down_o(converter_power_down_o), .conv_enable_o(conv_enable_o),
  .output_value_o(output_value_o), .interface_mode_bit_o(interface_mode_bit_o));
`default_nettype wire

// ---- tb/i2c_master_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  input  wire logic       clk_i,
  input  wire logic       sda_i,
  output var  logic       scl_low_o,
  output var  logic       sda_low_o,
  output var  logic       result_stb_o,
  output var  logic [7:0] result_val_o
);
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    result_stb_o = 1'b0;
    result_val_o = 8'h00;
  end
  task automatic wt(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // 16 clocks a bit: ten low so a slow-filtered slave settles before the rise
  task automatic bit_x(input logic b, output logic got);
    sda_low_o <= !b;
    wt(8);
    scl_low_o <= 1'b0;
    wt(5);
    got = sda_i;
    wt(1);
    scl_low_o <= 1'b1;
    wt(2);
  endtask
  task automatic start_c();
    sda_low_o <= 1'b1;
    wt(8);
    scl_low_o <= 1'b1;
    wt(2);
  endtask
  // Long low phase lets the slave drop its ack before the clock rises
  task automatic restart_c();
    sda_low_o <= 1'b0;
    wt(10);
    scl_low_o <= 1'b0;
    wt(8);
    start_c();
  endtask
  task automatic stop_c();
    sda_low_o <= 1'b1;
    wt(6);
    scl_low_o <= 1'b0;
    wt(8);
    sda_low_o <= 1'b0;
    wt(8);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic g;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], g);
    bit_x(1'b1, nack);
  endtask
  task automatic recv_byte(input logic last);
    logic [7:0] d;
    logic       g;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    result_val_o <= d;
    result_stb_o <= 1'b1;
    wt(1);
    result_stb_o <= 1'b0;
    bit_x(last, g);
  endtask
  task automatic reg_write(input logic [7:0] dev, input logic [7:0] idx,
                           input logic [7:0] d, output logic nack);
    logic g;
    start_c();
    send_byte(dev & 8'hfe, nack);
    if (!nack)
    begin
      send_byte(idx, g);
      send_byte(d, g);
    end
    stop_c();
  endtask
  task automatic reg_read(input logic [7:0] dev, input logic [7:0] idx, input int k,
                          output logic nack);
    logic g;
    start_c();
    send_byte(dev & 8'hfe, nack);
    if (!nack)
    begin
      send_byte(idx, g);
      restart_c();
      send_byte(dev | 8'h01, g);
      for (int i = 1; i <= k; i++)
        recv_byte(i == k);
    end
    stop_c();
  endtask
endmodule // i2c_master_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic               ref_clk_i = 1'b0;
  logic               rst_b_i   = 1'b0;
  logic               osc       = 1'b0;
  logic [1:0]         st        = 2'h0;
  logic               red       = 1'b0;
  logic [25:0]        raw       = 26'h0;
  logic               vld       = 1'b0;
  wire                scl;
  wire                sda;
  logic               scl_low, sda_low, scl_o, scl_oe, sda_o, sda_oe, pdn, cen, mode, stb, n;
  logic [15:0]        outv;
  logic [7:0]         rv, own, a, b;
  logic [23:0]        e;
  logic signed [25:0] sv;
  logic [7:0]         exp_q[$];
  logic [25:0]        lim [4] = '{26'h07fffff, 26'h0800000, 26'h3800000, 26'h37fffff};
  logic [7:0]         deb [3] = '{8'h04, 8'h08, 8'h0c};
  int                 failures = 0;
  int                 compares = 0;

  always #5 ref_clk_i = ~ref_clk_i;
  // Pull-ups: a released line reads high
  assign scl = !(scl_low || (scl_oe && !scl_o));
  assign sda = !(sda_low || (sda_oe && !sda_o));

  adc_result_i2c_slave_port adc_result_i2c_slave_port_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
    .oscillator_select_strap_i(osc), .osc_in_or_addr_strap_low_i(st[0]),
    .osc_out_or_addr_strap_high_i(st[1]), .reduced_pin_package_i(red),
    .conv_raw_i(raw), .conv_valid_i(vld), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .converter_power_down_o(pdn),
    .conv_enable_o(cen), .output_value_o(outv), .interface_mode_bit_o(mode));
  i2c_master_model i2c_master_model_i (
    .clk_i(ref_clk_i), .sda_i(sda), .scl_low_o(scl_low), .sda_low_o(sda_low),
    .result_stb_o(stb), .result_val_o(rv));

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Counts: compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic restart(input logic o, input logic [1:0] s, input logic r);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    osc <= o;
    st <= s;
    red <= r;
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i2c_master_model_i.reg_write(own, idx, d, n);
  endtask

  always @(posedge ref_clk_i)
    if (stb === 1'b1)
    begin
      if (exp_q.size() > 0)
        chk("read byte", {16'h0, exp_q.pop_front()}, {16'h0, rv});
      else
        chk("unexpected read byte", 24'h0, {16'h0, rv});
    end

  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    failures++;
    conclude();
  end

  initial
  begin
    void'($urandom(98));
    for (int c = 0; c < 6; c++)
    begin
      restart(c != 0, (c == 0) ? 2'h3 : 2'(c - 1), c == 5);
      own = (c == 5) ? 8'hd0 : (c == 0) ? 8'ha0 : 8'ha0 + {2'h0, st, 4'h0};
      wr(adc_i2c_pkg::SER_CTRL_OFS, 8'h73);
      chk("own address ack", 24'h0, {23'h0, n});
      // A wrongly accepted write here would also turn on debounce
      i2c_master_model_i.reg_write(own + 8'h20, adc_i2c_pkg::SER_CTRL_OFS, 8'h04, n);
      chk("foreign address ack", 24'h1, {23'h0, n});
      $display("test address %h done", own);
    end
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    i2c_master_model_i.reg_read(own, adc_i2c_pkg::SER_CTRL_OFS, 2, n);
    chk("mode bit", 24'h0, {23'h0, mode});
    // Ends on four-clock filtering so later tests run at the slowest setting
    foreach (deb[j])
    begin
      wr(adc_i2c_pkg::SER_CTRL_OFS, deb[j]);
      exp_q.push_back(deb[j]);
      i2c_master_model_i.reg_read(own, adc_i2c_pkg::SER_CTRL_OFS, 1, n);
      chk("debounce read ack", 24'h0, {23'h0, n});
    end
    $display("test control register done");
    for (int k = 0; k < 6; k++)
    begin
      sv = (k < 4) ? lim[k] : 26'($urandom);
      @(posedge ref_clk_i);
      raw <= sv;
      vld <= 1'b1;
      @(posedge ref_clk_i);
      vld <= 1'b0;
      e = (sv > 26'sh07fffff) ? 24'h7fffff : (sv < -26'sh0800000) ? 24'h800000 : sv[23:0];
      exp_q.push_back(e[7:0]);
      exp_q.push_back(e[15:8]);
      exp_q.push_back(e[23:16]);
      i2c_master_model_i.reg_read(own, adc_i2c_pkg::RESULT_LOW_OFS, 3, n);
    end
    wr(adc_i2c_pkg::RESULT_HIGH_OFS, ~e[23:16]);
    exp_q.push_back(e[23:16]);
    i2c_master_model_i.reg_read(own, adc_i2c_pkg::RESULT_HIGH_OFS, 1, n);
    $display("test result registers done");
    wr(adc_i2c_pkg::CONV_CTRL_OFS, 8'h80);
    chk("power down", 24'h0, {23'h0, cen});
    wr(adc_i2c_pkg::CONV_CTRL_OFS, 8'h00);
    chk("power up", 24'h1, {23'h0, cen});
    a = 8'($urandom);
    b = 8'($urandom);
    wr(adc_i2c_pkg::OUT_LOW_OFS, a);
    chk("output value", 24'h0, {8'h0, outv});
    wr(adc_i2c_pkg::OUT_HIGH_OFS, b);
    chk("output value", {8'h0, b, a}, {8'h0, outv});
    $display("test power and output done");
    chk("pending reads", 24'h0, 24'(exp_q.size()));
    conclude();
  end
endmodule // tb
`default_nettype wire

// ---- verilog/adc_result_i2c_slave_port.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_result_i2c_slave_port (
  input  wire logic                              ref_clk_i,
  input  wire logic                              rst_b_i,
  input  wire logic                              scl_i,
  input  wire logic                              sda_i,
  input  wire logic                              oscillator_select_strap_i,
  input  wire logic                              osc_in_or_addr_strap_low_i,
  input  wire logic                              osc_out_or_addr_strap_high_i,
  input  wire logic                              reduced_pin_package_i,
  input  wire logic [adc_i2c_pkg::RAW_W-1:0]     conv_raw_i,
  input  wire logic                              conv_valid_i,
  output logic                                   scl_o,
  output logic                                   scl_oe_o,
  output logic                                   sda_o,
  output logic                                   sda_oe_o,
  output logic                                   converter_power_down_o,
  output logic                                   conv_enable_o,
  output logic [15:0]                            output_value_o,
  output logic                                   interface_mode_bit_o
);

  typedef struct packed {
    adc_i2c_pkg::line_t      ln;
    adc_i2c_pkg::pins_t      pins;
    adc_i2c_pkg::phase_t     phase;
    adc_i2c_pkg::byte_kind_t kind;
    logic [3:0]              bitcnt;
    logic [7:0]              shift;
    logic                    rd;
    logic                    nack;
    logic [7:0]              idx;
    logic [3:0]              strap_sync1;
    logic [3:0]              strap_sync2;
    logic [1:0]              strap_wait;
    logic [7:0]              own_addr;
    logic [23:0]             result;
    logic [7:0]              ser_ctrl;
    logic [7:0]              conv_ctrl;
    logic [7:0]              out_shadow;
    logic [7:0]              out_low;
    logic [7:0]              out_high;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Clamp the wide filter output instead of letting it wrap
  function automatic logic [23:0] clamp(input logic [adc_i2c_pkg::RAW_W-1:0] v);
    logic signed [adc_i2c_pkg::RAW_W-1:0] sv;
    sv = $signed(v);
    if (sv > $signed({{(adc_i2c_pkg::RAW_W-24){1'b0}}, adc_i2c_pkg::RESULT_MAX}))
      clamp = adc_i2c_pkg::RESULT_MAX; // see R2
    else if (sv < $signed({{(adc_i2c_pkg::RAW_W-24){1'b1}}, adc_i2c_pkg::RESULT_MIN}))
      clamp = adc_i2c_pkg::RESULT_MIN; // see R2
    else
      clamp = v[23:0]; // see R1
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] a, input state_t s);
    read_reg = 8'h00;
    case (a)
      adc_i2c_pkg::RESULT_LOW_OFS:  read_reg = s.result[7:0]; // see R3
      adc_i2c_pkg::RESULT_MID_OFS:  read_reg = s.result[15:8]; // see R3
      adc_i2c_pkg::RESULT_HIGH_OFS: read_reg = s.result[23:16]; // see R3
      adc_i2c_pkg::CONV_CTRL_OFS:   read_reg = s.conv_ctrl;
      adc_i2c_pkg::OUT_LOW_OFS:     read_reg = s.out_low;
      adc_i2c_pkg::OUT_HIGH_OFS:    read_reg = s.out_high;
      adc_i2c_pkg::SER_CTRL_OFS:    read_reg = s.ser_ctrl & adc_i2c_pkg::SER_CTRL_MASK;
      default:                      read_reg = 8'h00;
    endcase
  endfunction

  function automatic logic [2:0] deb_need(input logic [1:0] sel);
    case (sel)
      2'h0:    deb_need = 3'h0; // see R12
      2'h1:    deb_need = adc_i2c_pkg::DEB_CLKS_TWO; // see R12
      default: deb_need = adc_i2c_pkg::DEB_CLKS_FOUR; // see R12
    endcase
  endfunction

  logic [2:0] need;
  logic       scl_rise;
  logic       scl_fall;
  logic       scl_high;
  logic       start_seen;
  logic       stop_seen;
  logic       addr_hit;
  logic [7:0] rd_cur;
  logic [7:0] rd_next;

  always_comb
  begin
    s_d = s_q;
    need = deb_need(s_q.ser_ctrl[adc_i2c_pkg::DEB_LSB +: 2]);
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    scl_high = 1'b0;
    start_seen = 1'b0;
    stop_seen = 1'b0;
    addr_hit = 1'b0;
    rd_cur = read_reg(s_q.idx, s_q);
    rd_next = read_reg(s_q.idx + 8'h01, s_q);

    s_d.ln.sync1 = {scl_i, sda_i};
    s_d.ln.sync2 = s_q.ln.sync1;
    s_d.ln.filt_prev = s_q.ln.filt;

    // Level must hold for the selected count before it is believed
    if (s_q.ln.sync2[adc_i2c_pkg::SCL] == s_q.ln.filt[adc_i2c_pkg::SCL])
      s_d.ln.cnt_scl = 3'h0;
    else if (s_q.ln.cnt_scl >= need)
    begin
      s_d.ln.filt[adc_i2c_pkg::SCL] = s_q.ln.sync2[adc_i2c_pkg::SCL]; // see R12
      s_d.ln.cnt_scl = 3'h0;
    end
    else
      s_d.ln.cnt_scl = s_q.ln.cnt_scl + 3'h1;

    if (s_q.ln.sync2[adc_i2c_pkg::SDA] == s_q.ln.filt[adc_i2c_pkg::SDA])
      s_d.ln.cnt_sda = 3'h0;
    else if (s_q.ln.cnt_sda >= need)
    begin
      s_d.ln.filt[adc_i2c_pkg::SDA] = s_q.ln.sync2[adc_i2c_pkg::SDA]; // see R12
      s_d.ln.cnt_sda = 3'h0;
    end
    else
      s_d.ln.cnt_sda = s_q.ln.cnt_sda + 3'h1;

    scl_high = s_q.ln.filt[adc_i2c_pkg::SCL] & s_q.ln.filt_prev[adc_i2c_pkg::SCL];
    scl_rise = s_q.ln.filt[adc_i2c_pkg::SCL] & ~s_q.ln.filt_prev[adc_i2c_pkg::SCL];
    scl_fall = ~s_q.ln.filt[adc_i2c_pkg::SCL] & s_q.ln.filt_prev[adc_i2c_pkg::SCL];
    start_seen = scl_high & ~s_q.ln.filt[adc_i2c_pkg::SDA]
                 & s_q.ln.filt_prev[adc_i2c_pkg::SDA]; // see R13
    stop_seen = scl_high & s_q.ln.filt[adc_i2c_pkg::SDA]
                & ~s_q.ln.filt_prev[adc_i2c_pkg::SDA]; // see R13

    // Straps are caught once, after the sync flops hold real pin values
    s_d.strap_sync1 = {reduced_pin_package_i, oscillator_select_strap_i,
                       osc_out_or_addr_strap_high_i, osc_in_or_addr_strap_low_i};
    s_d.strap_sync2 = s_q.strap_sync1;
    if (s_q.strap_wait != 2'h3)
      s_d.strap_wait = s_q.strap_wait + 2'h1;
    if (s_q.strap_wait == 2'h2)
    begin
      if (s_q.strap_sync2[3])
        s_d.own_addr = adc_i2c_pkg::ADDR_FIXED; // see R10
      else if (s_q.strap_sync2[2])
        s_d.own_addr = adc_i2c_pkg::ADDR_BASE + {2'h0, s_q.strap_sync2[1:0], 4'h0}; // see R9
      else
        s_d.own_addr = adc_i2c_pkg::ADDR_BASE; // see R8
    end

    // Results freeze while the converter is powered down
    if (conv_valid_i && !s_q.conv_ctrl[adc_i2c_pkg::PWR_DOWN_BIT]) // see R4
      s_d.result = clamp(conv_raw_i); // see R2

    // Only data is ever driven; the clock enable stays low
    s_d.pins.scl_oe = 1'b0; // see R6
    s_d.pins.scl_o = 1'b0;
    s_d.pins.sda_o = 1'b0; // see R7

    addr_hit = (s_q.shift[7:1] == s_q.own_addr[7:1]);

    if (stop_seen)
    begin
      s_d.phase = adc_i2c_pkg::ST_IDLE;
      s_d.pins.sda_oe = 1'b0;
    end
    else if (start_seen)
    begin
      // Repeated start keeps the index for the read that follows
      s_d.phase = adc_i2c_pkg::ST_RX; // see R17
      s_d.kind = adc_i2c_pkg::K_ADDR;
      s_d.bitcnt = 4'h0;
      s_d.pins.sda_oe = 1'b0;
    end
    else
    begin
      case (s_q.phase)
        adc_i2c_pkg::ST_IDLE: s_d.pins.sda_oe = 1'b0;
        adc_i2c_pkg::ST_RX:
        begin
          if (scl_rise && s_q.bitcnt < adc_i2c_pkg::BITS_PER_BYTE)
          begin
            s_d.shift = {s_q.shift[6:0], s_q.ln.filt[adc_i2c_pkg::SDA]}; // see R14, R15
            s_d.bitcnt = s_q.bitcnt + 4'h1;
          end
          else if (scl_fall && s_q.bitcnt == adc_i2c_pkg::BITS_PER_BYTE)
          begin
            s_d.phase = adc_i2c_pkg::ST_ACK;
            s_d.pins.sda_oe = 1'b1; // see R16
            case (s_q.kind)
              adc_i2c_pkg::K_ADDR:
              begin
                if (addr_hit) // see R19
                  s_d.rd = s_q.shift[0];
                else
                begin
                  s_d.phase = adc_i2c_pkg::ST_IDLE;
                  s_d.pins.sda_oe = 1'b0;
                end
              end
              adc_i2c_pkg::K_INDEX: s_d.idx = s_q.shift; // see R17, R18
              default:
              begin
                case (s_q.idx) // see R18
                  adc_i2c_pkg::SER_CTRL_OFS:
                    s_d.ser_ctrl = s_q.shift & adc_i2c_pkg::SER_CTRL_MASK;
                  adc_i2c_pkg::CONV_CTRL_OFS: s_d.conv_ctrl = s_q.shift;
                  adc_i2c_pkg::OUT_LOW_OFS: s_d.out_shadow = s_q.shift; // see R5
                  adc_i2c_pkg::OUT_HIGH_OFS:
                  begin
                    s_d.out_high = s_q.shift;
                    s_d.out_low = s_q.out_shadow; // see R5
                  end
                  default: s_d.out_shadow = s_q.out_shadow;
                endcase
                s_d.idx = s_q.idx + 8'h01;
              end
            endcase
          end
        end
        adc_i2c_pkg::ST_ACK:
        begin
          if (scl_fall) // see R15
          begin
            s_d.bitcnt = 4'h0;
            if (s_q.kind == adc_i2c_pkg::K_ADDR && s_q.rd)
            begin
              s_d.phase = adc_i2c_pkg::ST_TX;
              s_d.shift = rd_cur;
              s_d.pins.sda_oe = ~rd_cur[7];
            end
            else
            begin
              s_d.phase = adc_i2c_pkg::ST_RX;
              s_d.pins.sda_oe = 1'b0;
              s_d.kind = (s_q.kind == adc_i2c_pkg::K_ADDR) ? adc_i2c_pkg::K_INDEX
                                                          : adc_i2c_pkg::K_DATA;
            end
          end
        end
        adc_i2c_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (s_q.bitcnt == adc_i2c_pkg::BITS_PER_BYTE - 4'h1)
            begin
              s_d.phase = adc_i2c_pkg::ST_MACK;
              s_d.pins.sda_oe = 1'b0;
            end
            else
            begin
              s_d.shift = {s_q.shift[6:0], 1'b0}; // see R15
              s_d.pins.sda_oe = ~s_q.shift[6]; // see R7
              s_d.bitcnt = s_q.bitcnt + 4'h1;
            end
          end
        end
        adc_i2c_pkg::ST_MACK:
        begin
          if (scl_rise)
            s_d.nack = s_q.ln.filt[adc_i2c_pkg::SDA];
          else if (scl_fall)
          begin
            if (s_q.nack)
              s_d.phase = adc_i2c_pkg::ST_IDLE; // see R16
            else
            begin
              s_d.phase = adc_i2c_pkg::ST_TX;
              s_d.bitcnt = 4'h0;
              s_d.idx = s_q.idx + 8'h01;
              s_d.shift = rd_next;
              s_d.pins.sda_oe = ~rd_next[7];
            end
          end
        end
        default:
        begin
          s_d.phase = adc_i2c_pkg::ST_IDLE;
          s_d.pins.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      s_q <= '0;
      s_q.ln.sync1 <= 2'h3;
      s_q.ln.sync2 <= 2'h3;
      s_q.ln.filt <= 2'h3;
      s_q.ln.filt_prev <= 2'h3;
      s_q.phase <= adc_i2c_pkg::ST_IDLE;
      s_q.kind <= adc_i2c_pkg::K_ADDR;
      s_q.own_addr <= adc_i2c_pkg::ADDR_BASE;
      s_q.ser_ctrl <= adc_i2c_pkg::SER_CTRL_RESET;
      s_q.conv_ctrl <= adc_i2c_pkg::CONV_CTRL_RESET;
    end
    else
      s_q <= s_d;
  end

  assign scl_o = s_q.pins.scl_o;
  assign scl_oe_o = s_q.pins.scl_oe;
  assign sda_o = s_q.pins.sda_o;
  assign sda_oe_o = s_q.pins.sda_oe;
  assign converter_power_down_o = s_q.conv_ctrl[adc_i2c_pkg::PWR_DOWN_BIT]; // see R4
  assign conv_enable_o = ~s_q.conv_ctrl[adc_i2c_pkg::PWR_DOWN_BIT]; // see R4
  assign output_value_o = {s_q.out_high, s_q.out_low};
  assign interface_mode_bit_o = s_q.ser_ctrl[adc_i2c_pkg::MODE_BIT]; // see R11

endmodule // adc_result_i2c_slave_port
`default_nettype wire
